// ### timer_pkg.sv
// Purpose: Constants and types for the 16-bit compare/PWM timer.
// Assumes: AXI4-Lite register access, one word per register.
// Notes:   Offsets are byte addresses.
package timer_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] off_counter_low  = 8'h00;
	localparam logic [7:0] off_counter_high = 8'h04;
	localparam logic [7:0] off_compare_a_lo = 8'h08;
	localparam logic [7:0] off_compare_a_hi = 8'h0c;
	localparam logic [7:0] off_compare_p    = 8'h10;
	localparam logic [7:0] off_control      = 8'h14;
	localparam logic [7:0] off_status       = 8'h18;

	// ==========================================================
	// Control word fields
	localparam int ctl_run       = 0;
	localparam int ctl_clear_sel = 1;
	localparam int ctl_swap      = 2;
	localparam int ctl_invert    = 3;
	localparam int ctl_init_lvl  = 4;
	localparam int ctl_act_lo    = 5;
	localparam int ctl_act_hi    = 6;
	localparam int ctl_mode_lo   = 7;
	localparam int ctl_mode_hi   = 8;
	localparam int ctl_width     = 9;
	localparam logic [8:0] ctl_reset = 9'h000;

	// Status fields
	localparam int st_flag_a = 0;
	localparam int st_flag_p = 1;

	// ==========================================================
	// Modes and output actions
	typedef enum logic [1:0] {
		mode_compare = 2'b00,
		mode_capture = 2'b01,
		mode_pwm     = 2'b10,
		mode_timer   = 2'b11
	} mode_type;

	localparam logic [1:0] act_none   = 2'b00;
	localparam logic [1:0] act_low    = 2'b01;
	localparam logic [1:0] act_high   = 2'b10;
	localparam logic [1:0] act_toggle = 2'b11;
	localparam logic [1:0] act_pwm_on = 2'b10;

	localparam logic [1:0] resp_okay   = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;

	localparam logic [15:0] count_max = 16'hffff;
	localparam logic [15:0] count_one = 16'h0001;
	localparam logic [7:0]  byte_zero = 8'h00;

endpackage

// ### timer_core.sv
// Purpose: 16-bit count-up timer with A/P compare, compare, timer and PWM modes.
// Assumes: tick is a one-cycle timer clock enable from an outside clock selector.
// Notes:   Registers over AXI4-Lite; no interrupt logic.
`timescale 1ns/100ps
`default_nettype none

module timer_core (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        tick,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output var  logic        timer_out,
	output var  logic        timer_out_enable,
	output var  logic        match_a_flag,
	output var  logic        match_p_flag
);
	import timer_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic                 aw_held;
		logic [7:0]           aw_addr;
		logic                 w_held;
		logic [31:0]          w_data;
		logic [3:0]           w_strb;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
		logic [15:0]          counter;
		logic [15:0]          compare_a_value;
		logic [7:0]           compare_p_value;
		logic [ctl_width-1:0] control;
		logic                 run_last;
		logic                 level;
		logic                 flag_a;
		logic                 flag_p;
		logic                 pin;
		logic                 pin_en;
		// Bus readies kept as flops so no port is driven through a gate
		logic                 aw_ready;
		logic                 w_ready;
		logic                 ar_ready;
	} state_type;

	state_type state;
	state_type next_state;

	function automatic logic [7:0] lane(input logic [7:0] old, input logic [31:0] d,
			input logic [3:0] s);
		lane = s[0] ? d[7:0] : old;
	endfunction

	// Last count of the P period; a zero P runs the full 16 bits
	function automatic logic p_end(input logic [15:0] count, input logic [7:0] p);
		if (p == byte_zero) begin
			p_end = count == count_max;
		end else begin
			// Looking one count ahead makes the period exactly P times 256 ticks
			p_end = (count + count_one) == {p, byte_zero};
		end
	endfunction

	// Sticky flag: a set in the same cycle as a software clear wins
	function automatic logic sticky(input logic hit, input logic old, input logic clr);
		sticky = hit | (old & ~clr);
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		logic       run;
		logic       run_rise;
		mode_type   mode;
		logic [1:0] act;
		logic       match_a;
		logic       match_p;
		logic       live;
		logic       clear;
		logic       set_a;
		logic       set_p;
		logic       clr_a;
		logic       clr_p;
		logic       duty_on;
		logic       wr;
		logic [15:0] period;
		logic [16:0] duty;
		logic       wave;

		next_state = state;
		run      = state.control[ctl_run];
		run_rise = run & ~state.run_last;
		mode     = mode_type'({state.control[ctl_mode_hi], state.control[ctl_mode_lo]});
		act      = {state.control[ctl_act_hi], state.control[ctl_act_lo]};
		clr_a    = 1'b0;
		clr_p    = 1'b0;
		// The tick on which run rises only clears, so a stale count cannot match
		live     = tick && run && !run_rise;
		match_a  = 1'b0;
		match_p  = 1'b0;
		clear    = 1'b0;
		set_a    = 1'b0;
		set_p    = 1'b0;
		duty_on  = 1'b0;
		wr       = 1'b0;
		period   = '0;
		duty     = '0;
		wave     = 1'b0;
		next_state.run_last = run;

		// AXI write channel: address and data in either order
		if (s_axi_awvalid && state.aw_ready) begin
			next_state.aw_held = 1'b1;
			next_state.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && state.w_ready) begin
			next_state.w_held = 1'b1;
			next_state.w_data = s_axi_wdata;
			next_state.w_strb = s_axi_wstrb;
		end
		if (state.bvalid && s_axi_bready) begin
			next_state.bvalid = 1'b0;
		end
		wr = state.aw_held && state.w_held && !state.bvalid;
		if (wr) begin
			next_state.aw_held = 1'b0;
			next_state.w_held  = 1'b0;
			next_state.bvalid  = 1'b1;
			next_state.bresp   = resp_okay;
			if (state.aw_addr == off_compare_a_lo) begin
				next_state.compare_a_value[7:0] = lane(state.compare_a_value[7:0],
					state.w_data, state.w_strb);
			end else if (state.aw_addr == off_compare_a_hi) begin
				next_state.compare_a_value[15:8] = lane(state.compare_a_value[15:8],
					state.w_data, state.w_strb);
			end else if (state.aw_addr == off_compare_p) begin
				next_state.compare_p_value = lane(state.compare_p_value,
					state.w_data, state.w_strb);
			end else if (state.aw_addr == off_control) begin
				if (state.w_strb[0]) begin
					next_state.control[7:0] = state.w_data[7:0];
				end
				if (state.w_strb[1]) begin
					next_state.control[ctl_mode_hi] = state.w_data[ctl_mode_hi];
				end
			end else if (state.aw_addr == off_status) begin
				// Write one to clear
				clr_a = state.w_strb[0] & state.w_data[st_flag_a];
				clr_p = state.w_strb[0] & state.w_data[st_flag_p];
			end else if (state.aw_addr == off_counter_low ||
					state.aw_addr == off_counter_high) begin
				next_state.bresp = resp_okay;
			end else begin
				next_state.bresp = resp_slverr;
			end
		end

		// AXI read channel
		if (state.rvalid && s_axi_rready) begin
			next_state.rvalid = 1'b0;
		end
		if (s_axi_arvalid && state.ar_ready) begin
			next_state.rvalid = 1'b1;
			next_state.rresp  = resp_okay;
			next_state.rdata  = '0;
			if (s_axi_araddr == off_counter_low) begin
				next_state.rdata[7:0] = state.counter[7:0];
			end else if (s_axi_araddr == off_counter_high) begin
				next_state.rdata[7:0] = state.counter[15:8];
			end else if (s_axi_araddr == off_compare_a_lo) begin
				next_state.rdata[7:0] = state.compare_a_value[7:0];
			end else if (s_axi_araddr == off_compare_a_hi) begin
				next_state.rdata[7:0] = state.compare_a_value[15:8];
			end else if (s_axi_araddr == off_compare_p) begin
				next_state.rdata[7:0] = state.compare_p_value;
			end else if (s_axi_araddr == off_control) begin
				next_state.rdata[ctl_width-1:0] = state.control;
			end else if (s_axi_araddr == off_status) begin
				next_state.rdata[st_flag_a] = state.flag_a;
				next_state.rdata[st_flag_p] = state.flag_p;
			end else begin
				next_state.rresp = resp_slverr;
			end
		end

		// ======================================================
		// Comparators, evaluated on a timer tick
		match_a  = live && state.counter == state.compare_a_value;
		match_p  = live && p_end(state.counter, state.compare_p_value);
		if (mode == mode_pwm) begin
			// Clear-select ignored here
			set_a = match_a;
			set_p = match_p;
			if (state.control[ctl_swap]) begin
				clear = match_a;
			end else begin
				clear = set_p;
			end
		end else if (mode == mode_compare || mode == mode_timer) begin
			if (state.control[ctl_clear_sel]) begin
				set_a = match_a;
				clear = match_a;
			end else begin
				set_a = match_a;
				set_p = match_p;
				clear = set_p;
			end
		end

		// Counter
		if (run_rise) begin
			next_state.counter = '0;
		end else if (tick && run) begin
			if (clear) begin
				next_state.counter = '0;
			end else begin
				next_state.counter = state.counter + count_one;
			end
		end

		// Sticky flags: a set wins over a clear in the same cycle
		next_state.flag_a = sticky(set_a, state.flag_a, clr_a);
		next_state.flag_p = sticky(set_p, state.flag_p, clr_p);

		// ======================================================
		// Output pin
		if (run_rise) begin
			next_state.level = state.control[ctl_init_lvl];
		end else if (set_a && mode == mode_compare) begin
			case (act)
				act_low:    next_state.level = 1'b0;
				act_high:   next_state.level = 1'b1;
				act_toggle: next_state.level = ~state.level;
				default:    next_state.level = state.level;
			endcase
		end

		// Duty compare: one past the end of the period reads as full on
		if (state.control[ctl_swap]) begin
			period = state.compare_a_value;
			duty   = (state.compare_p_value == byte_zero) ? 17'h10000 :
				{1'b0, state.compare_p_value, byte_zero};
		end else begin
			period = (state.compare_p_value == byte_zero) ? count_max :
				{state.compare_p_value, byte_zero} - count_one;
			duty   = {1'b0, state.compare_a_value};
		end
		duty_on = ({1'b0, state.counter} < duty) || (duty > {1'b0, period});
		wave = run & duty_on;
		if (!state.control[ctl_init_lvl]) begin
			wave = ~wave;
		end

		next_state.pin_en = 1'b1;
		if (mode == mode_pwm) begin
			case (act)
				act_pwm_on: next_state.pin = wave;
				act_toggle: next_state.pin = wave;
				// Forced levels: 01 high, 00 low; counting goes on
				act_low:    next_state.pin = 1'b1;
				default:    next_state.pin = 1'b0;
			endcase
			next_state.pin = next_state.pin ^ state.control[ctl_invert];
		end else if (mode == mode_compare) begin
			next_state.pin = state.level ^ state.control[ctl_invert];
		end else begin
			next_state.pin    = 1'b0;
			next_state.pin_en = 1'b0;
		end

		// Readies are registered from the next hold bits and rvalid, so they change on the same edge
		next_state.aw_ready = ~next_state.aw_held;
		next_state.w_ready  = ~next_state.w_held;
		next_state.ar_ready = ~next_state.rvalid;
	end

	// ==========================================================
	// Registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state         <= '0;
			state.control <= ctl_reset;
			state.aw_ready <= 1'b1;
			state.w_ready  <= 1'b1;
			state.ar_ready <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	assign s_axi_awready    = state.aw_ready;
	assign s_axi_wready     = state.w_ready;
	assign s_axi_bvalid     = state.bvalid;
	assign s_axi_bresp      = state.bresp;
	assign s_axi_arready    = state.ar_ready;
	assign s_axi_rvalid     = state.rvalid;
	assign s_axi_rdata      = state.rdata;
	assign s_axi_rresp      = state.rresp;
	assign timer_out        = state.pin;
	assign timer_out_enable = state.pin_en;
	assign match_a_flag     = state.flag_a;
	assign match_p_flag     = state.flag_p;

endmodule // timer_core

`default_nettype wire

// ### pin_load.sv
// Purpose: Load on the timer pin; counts high cycles and level changes
// Assumes: Pin released while the enable is low
// Notes:   A released pin shows the inverse of its last driven level
`timescale 1ns/100ps
`default_nettype none
// ========================================
// Load model
module pin_load (
	input  wire logic        aclk,
	input  wire logic        timer_out,
	input  wire logic        timer_out_enable,
	input  wire logic        clear_counts,
	output var  logic [31:0] high_cycles,
	output var  logic [31:0] edges,
	output var  logic        pin
);
	logic last;
	logic prev;
	// No pull on the line, so a stale level must not pass for a driven one
	assign pin = timer_out_enable ? timer_out : !last;
	always_ff @(posedge aclk) begin
		if (timer_out_enable)
			last <= timer_out;
		prev <= pin;
		if (clear_counts) begin
			high_cycles <= 32'h0;
			edges <= 32'h0;
		end else begin
			high_cycles <= high_cycles + 32'(pin);
			edges <= edges + 32'(pin != prev);
		end
	end
endmodule // pin_load
`default_nettype wire

// ### timer_chk.sv
// Purpose: Port assertions for timer_core
// Assumes: Control word mirrored from completed bus writes
// Notes:   Mirror lags the core, so checks wait until it settles
`timescale 1ns/100ps
`default_nettype none
// ========================================
// Checker
module timer_chk
	import timer_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        timer_out,
	input wire logic        timer_out_enable,
	input wire logic        match_a_flag,
	input wire logic        match_p_flag
);
	logic [7:0]  adr;
	logic [31:0] dat;
	logic [8:0]  ctl;
	logic [1:0]  quiet;
	logic [1:0]  md;
	logic        settled;
	assign md = ctl[8:7];
	assign settled = quiet == 2'h3;
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready)
			adr <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready)
			dat <= s_axi_wdata;
		if (!aresetn) begin
			ctl <= ctl_reset;
			quiet <= 2'h0;
		end else if ($rose(s_axi_bvalid) && adr == off_control) begin
			ctl <= dat[8:0];
			quiet <= 2'h0;
		end else if (!settled) begin
			quiet <= quiet + 2'h1;
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_a_sticky; $past(aresetn) && $fell(match_a_flag) |-> s_axi_bvalid; endproperty
	a_a_sticky: assert property (p_a_sticky) else $error("flag a dropped");
	property p_p_sticky; match_p_flag ##1 !s_axi_bvalid |-> match_p_flag; endproperty
	a_p_sticky: assert property (p_p_sticky) else $error("flag p dropped");
	property p_no_p; settled && ctl[ctl_clear_sel] && md == mode_compare |-> !$rose(match_p_flag); endproperty
	a_no_p: assert property (p_no_p) else $error("flag p with clear on a");
	property p_undriven; settled && md == mode_timer |-> !timer_out_enable; endproperty
	a_undriven: assert property (p_undriven) else $error("pin driven in timer mode");
	property p_forced; settled && ctl[ctl_run] && md == mode_pwm && !ctl[ctl_act_hi]
		|-> timer_out == (ctl[ctl_act_lo] ^ ctl[ctl_invert]); endproperty
	a_forced: assert property (p_forced) else $error("forced pwm level");
	property p_hold; settled && md == mode_compare && ctl[6:5] == act_none |-> $stable(timer_out);
	endproperty
	a_hold: assert property (p_hold) else $error("pin moved without action");
	property p_init; $rose(ctl[ctl_run]) && md == mode_compare && ctl[6:5] == act_none
		|-> ##3 timer_out == ctl[ctl_init_lvl]; endproperty
	a_init: assert property (p_init) else $error("initial level");
	property p_pwm_p; settled && ctl[ctl_run] && md == mode_pwm |-> ##[0:700] match_p_flag;
	endproperty
	a_pwm_p: assert property (p_pwm_p) else $error("no p flag in pwm");
endmodule // timer_chk
bind timer_core timer_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.timer_out(timer_out), .timer_out_enable(timer_out_enable),
	.match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
`default_nettype wire

// ### standard_16bit_timer_module_tb_top.sv
// Purpose: Self-checking bench for timer_core
// Assumes: tick held high, so timer clocks equal bus clocks
// Notes:   Pin counts span whole periods, so the phase drops out
`timescale 1ns/100ps
`default_nettype none
`define chk(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected %s exp %0h got %0h", n, e, g); end end
// ========================================
// Bench top
module standard_16bit_timer_module_tb_top;
	import timer_pkg::*;
	logic        aclk, aresetn, tick, aw_v, aw_r, w_v, w_r, b_v, b_r;
	logic        ar_v, ar_r, r_v, r_r, t_out, t_oe, fa, fp, clr;
	logic [7:0]  aw_a, ar_a;
	logic [31:0] w_d, r_d, highs, edges;
	logic [3:0]  w_s;
	logic [1:0]  b_s, r_s;
	logic [15:0] a;
	int          mismatches, comparisons, cycles, per, hi, ex, ini, inv;
	timer_core dut (
		.aclk(aclk), .aresetn(aresetn), .tick(tick),
		.s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
		.s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
		.s_axi_bresp(b_s), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
		.s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
		.s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
		.timer_out(t_out), .timer_out_enable(t_oe), .match_a_flag(fa), .match_p_flag(fp));
	pin_load load (.aclk(aclk), .timer_out(t_out), .timer_out_enable(t_oe),
		.clear_counts(clr), .high_cycles(highs), .edges(edges), .pin());
	task automatic give_verdict();
		if (mismatches == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge aclk);
		aw_a <= ad;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		do begin
			@(posedge aclk);
			if (aw_r)
				aw_v <= 1'b0;
			if (w_r)
				w_v <= 1'b0;
		end while (!b_v);
		b_r <= 1'b0;
		`chk("bresp", resp_okay, b_s)
	endtask
	task automatic rc(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		ar_a <= ad;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		do begin
			@(posedge aclk);
			if (ar_r)
				ar_v <= 1'b0;
		end while (!r_v);
		r_r <= 1'b0;
		`chk("rdata", e, r_d)
		`chk("rresp", er, r_s)
	endtask
	function automatic logic [31:0] cw(input int md, act, il, iv, sw, cs);
		return 32'((md << ctl_mode_lo) | (act << ctl_act_lo) | (il << ctl_init_lvl)
			| (iv << ctl_invert) | (sw << ctl_swap) | (cs << ctl_clear_sel));
	endfunction
	// Run is raised last so every case starts from a cleared counter
	task automatic cfg(input logic [15:0] av, input logic [7:0] p, input logic [31:0] c);
		wr(off_compare_a_lo, {24'h0, av[7:0]});
		wr(off_compare_a_hi, {24'h0, av[15:8]});
		wr(off_compare_p, {24'h0, p});
		wr(off_control, c);
		wr(off_status, 32'h3);
		wr(off_control, c | 32'h1);
	endtask
	task automatic measure(input int w);
		@(posedge aclk);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		repeat (w) @(posedge aclk);
		#1;
	endtask
	initial begin
		aclk = 1'b0;
		forever #25 aclk = !aclk;
	end
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		{aresetn, tick, aw_v, w_v, b_r, ar_v, r_r, clr} = 8'h0;
		{aw_a, ar_a, w_d, w_s} = {16'h0, 32'h0, 4'hf};
		void'($urandom(86717));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		tick <= 1'b1;
		for (int i = 0; i < 7; i++)
			rc(8'(i * 4), 32'h0, resp_okay);
		rc(8'h1c, 32'h0, resp_slverr);
		a = 16'($urandom);
		hi = $urandom % 256;
		wr(off_compare_a_lo, {24'h0, a[7:0]});
		wr(off_compare_a_hi, {24'h0, a[15:8]});
		wr(off_compare_p, 32'(hi));
		wr(off_counter_low, 32'hff);
		rc(off_compare_a_lo, {24'h0, a[7:0]}, resp_okay);
		rc(off_compare_a_hi, {24'h0, a[15:8]}, resp_okay);
		rc(off_compare_p, 32'(hi), resp_okay);
		rc(off_counter_low, 32'h0, resp_okay);
		// A stays above the first P match, which must still raise no flag
		for (int act = 0; act < 4; act++) begin
			a = 16'h200 + 16'($urandom % 64);
			cfg(a, 8'h1, cw(0, act, act < 2, 0, 0, 1));
			repeat (a + 8) @(posedge aclk);
			measure(4 * (a + 1));
			`chk("edges", act == 3 ? 4 : 0, edges)
			if (act != 3) `chk("pin", act != 1, t_out)
			`chk("flags", 2'h2, {fa, fp})
		end
		for (int m = 0; m < 2; m++) begin
			cfg(16'h40, 8'h1, cw(3 * m, 3, 0, 0, 0, 0));
			repeat (300) @(posedge aclk);
			measure(1024);
			`chk("enable", m == 0, t_oe)
			`chk("flags", 2'h3, {fa, fp})
			if (m == 0) `chk("edges", 4, edges)
			rc(off_counter_high, 32'h0, resp_okay);
		end
		wr(off_control, 32'h0);
		rc(off_status, 32'h3, resp_okay);
		wr(off_status, 32'h3);
		rc(off_status, 32'h0, resp_okay);
		for (int k = 0; k < 5; k++) begin
			ini = $urandom % 2;
			inv = $urandom % 2;
			a = k == 1 ? 16'h12c : k == 2 ? 16'h200 + 16'($urandom % 64) : 16'(1 + $urandom % 255);
			per = k == 2 ? a + 1 : 256;
			hi = k == 0 ? a : 256;
			cfg(a, 8'h1, cw(2, k < 3 ? 2 : k - 3, ini, inv, k == 2, 1));
			repeat (20) @(posedge aclk);
			measure(2 * per);
			ex = k > 2 ? (((k == 4) ^ inv) ? 2 * per : 0) : (ini ^ inv) ? 2 * hi : 2 * (per - hi);
			`chk("high", ex, highs)
			`chk("flag_p", 1'b1, fp)
		end
		give_verdict();
	end
endmodule // standard_16bit_timer_module_tb_top
`default_nettype wire
